// ---- pkg/dufb_pkg.sv ----
package dufb_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] UNIT_EN_ADDR = 8'h00;
  localparam logic [7:0] CLOCK_MODE_ADDR = 8'h04;
  localparam logic [7:0] CRYSTAL_CTRL_ADDR = 8'h08;
  localparam logic [7:0] FAST_TRIM_ADDR = 8'h0C;
  localparam logic [7:0] STATUS_ADDR = 8'h10;
  localparam logic [7:0] PC_ADDR = 8'h14;
  // unit enable fields
  localparam int UNIT_EN_PRIMARY_BIT = 0;
  localparam int UNIT_EN_SECONDARY_BIT = 1;
  localparam logic [1:0] UNIT_EN_RESET = 2'h1;
  // clock mode fields
  localparam int CLOCK_MODE_FAST_EN_BIT = 4;
  localparam int CLOCK_MODE_SLOW_EN_BIT = 2;
  localparam int CLOCK_MODE_SEL_LSB = 0;
  localparam int CLOCK_MODE_DIV_LSB = 5;
  localparam logic [7:0] CLOCK_MODE_RESET = 8'h14;
  localparam logic [1:0] CLK_SEL_SLOW = 2'h0;
  localparam logic [1:0] CLK_SEL_FAST = 2'h1;
  localparam logic [1:0] CLK_SEL_CRYSTAL = 2'h2;
  // crystal control fields
  localparam int CRYSTAL_EN_BIT = 7;
  localparam logic [7:0] CRYSTAL_CTRL_RESET = 8'h00;
  localparam logic [7:0] FAST_TRIM_RESET = 8'h80;
  // status fields
  localparam int STATUS_BOOT_DONE_BIT = 0;
  localparam int STATUS_SINGLE_BIT = 1;
  localparam int STATUS_UNSUPPORTED_BIT = 2;
  localparam int STATUS_SLOT_BIT = 3;
  // program memory map
  localparam int PC_WIDTH = 12;
  localparam logic [11:0] PRIMARY_RESET_VECTOR = 12'h000;
  localparam logic [11:0] SECONDARY_RESET_VECTOR = 12'h001;
  localparam logic [11:0] IRQ_VECTOR = 12'h010;
  localparam logic [11:0] USER_LOW_FIRST = 12'h002;
  localparam logic [11:0] USER_LOW_LAST = 12'h00F;
  localparam logic [11:0] USER_HIGH_FIRST = 12'h011;
  localparam logic [11:0] USER_HIGH_LAST = 12'hFF7;
  localparam logic [11:0] SYSTEM_FIRST = 12'hFF8;
  // data memory
  localparam int DMEM_BYTES = 208;
  localparam logic [7:0] DMEM_LAST = 8'hCF;
  // boot wait in slow oscillator cycles
  localparam int BOOT_WAIT_SLOW_CYCLES = 1024;
  localparam logic [10:0] BOOT_WAIT_COUNT = 11'(BOOT_WAIT_SLOW_CYCLES);
  typedef enum logic [2:0] {
    DUFB_OP_PASS,
    DUFB_OP_ADD,
    DUFB_OP_SUB,
    DUFB_OP_AND,
    DUFB_OP_OR,
    DUFB_OP_XOR,
    DUFB_OP_BSET,
    DUFB_OP_BCLR
  } dufb_op_e;
endpackage

// ---- verilog/dufb_sequencer.sv ----
//Contract
//- single-unit mode keeps the secondary unit off; only the primary executes
//- wait and delay instructions are unsupported in single-unit mode
//- primary starts at address 0x0, secondary at 0x1 after reset
//- only the primary takes interrupts, vectoring to 0x10
//- program memory is 4Kx16; top eight words are system data
//- user code lives at 0x002-0x00F and 0x011-0xFF7
//- 0x001 is secondary start, or plain sequential primary code in single mode
//- outside the vectors any unit may run code at any address
//- wait 1024 slow oscillator cycles after power-on before the first fetch
//- system clock comes from the slow oscillator after boot
//- secondary unit disabled after reset; primary boot code runs alone
//- either unit reads or writes any data byte or bit in one cycle
//- any data byte can act as an 8-bit pointer reaching all 208 bytes
//- each unit has its own software-set stack pointer
//- one shared ALU; operands from instruction, accumulator or memory
//- crystal, fast and slow oscillators enabled independently by their bits
//- after boot both internal oscillators run, crystal is off
//- software picks the clock source and divider in the clock mode register
//- fast oscillator is trimmed by its calibration register
//- two-unit mode grants alternating exclusive cycles to the units
//- either unit can enable or disable either unit via the enable register
//- each unit has a 12-bit pc, incremented per owned cycle, replaced on jumps
`timescale 1ns/1ps
`default_nettype none
module dufb_sequencer (
  input wire logic clock, // 25 MHz system clock
  input wire logic reset, // async, active high
  input wire logic [7:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped offset
  input wire logic slow_osc_clk, // slow oscillator, asynchronous
  input wire logic single_unit_strap, // single-unit option, held at boot
  input wire logic irq_req, // interrupt request, level
  input wire logic branch_valid, // owner of this slot jumps
  input wire logic [11:0] branch_target, // jump destination
  input wire logic exec_valid, // datapath operation this cycle
  input wire logic exec_unit, // unit issuing the operation
  input wire logic [2:0] alu_op, // shared alu operation
  input wire logic src_mem, // operand b from memory, else immediate
  input wire logic dst_mem, // result to memory, else accumulator
  input wire logic [7:0] imm, // immediate operand
  input wire logic [7:0] mem_addr, // data address or pointer location
  input wire logic mem_indirect, // take address from the byte at mem_addr
  input wire logic [2:0] bit_idx, // bit for set and clear
  input wire logic sp_load, // load stack pointer from immediate
  input wire logic wait_delay_op, // wait or delay instruction issued
  output logic fetch_valid, // fetch request this cycle
  output logic [11:0] fetch_addr, // program word address
  output logic fetch_unit, // 0 primary, 1 secondary
  output logic irq_taken, // interrupt vectored, one cycle
  output logic [7:0] mem_rdata, // memory byte read by last operation
  output logic [7:0] acc_primary, // primary accumulator
  output logic [7:0] acc_secondary, // secondary accumulator
  output logic [7:0] sp_primary, // primary stack pointer
  output logic [7:0] sp_secondary, // secondary stack pointer
  output logic crystal_osc_en, // crystal oscillator enable
  output logic fast_osc_en, // fast internal oscillator enable
  output logic slow_osc_en, // slow internal oscillator enable
  output logic [1:0] sysclk_sel, // system clock source
  output logic [2:0] sysclk_div, // system clock divider code
  output logic [7:0] fast_trim, // fast oscillator trim
  output logic boot_done // boot wait finished
);
  logic [2:0] slow_sync;
  logic slow_level;
  logic [10:0] boot_count;
  logic single_mode;
  logic [1:0] unit_en;
  logic [7:0] clock_mode;
  logic [7:0] crystal_ctrl;
  logic unsupported;
  logic slot;
  logic [11:0] pc [0:1];
  localparam int DMEM_SIZE = dufb_pkg::DMEM_BYTES;
  logic [7:0] dmem [0:DMEM_SIZE-1];
  logic wr_access;
  logic rd_setup;
  logic mapped;
  logic [31:0] next_rdata;
  logic owner_en;
  logic take_irq;
  logic [11:0] next_fetch;
  logic unit_live;
  logic [7:0] eff_addr;
  logic eff_ok;
  logic [7:0] mem_byte;
  logic [7:0] operand;
  logic [7:0] acc_sel;
  logic [7:0] alu_result;

  // slow oscillator edges: a change counts once stages two and three agree
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      slow_sync <= 3'h0;
      slow_level <= 1'b0;
    end
    else
    begin
      slow_sync <= {slow_sync[1:0], slow_osc_clk};
      if (slow_sync[1] == slow_sync[2])
        slow_level <= slow_sync[2];
    end
  end

  // power-on wait before any fetch
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      boot_count <= 11'h000;
      boot_done <= 1'b0;
    end
    else if (!boot_done && slow_sync[1] == slow_sync[2] && slow_sync[2] && !slow_level)
    begin
      boot_count <= boot_count + 11'h001;
      if (boot_count + 11'h001 == dufb_pkg::BOOT_WAIT_COUNT)
        boot_done <= 1'b1;
    end
  end

  // option strap follows the pin until boot ends, then is frozen
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      single_mode <= 1'b0;
    else if (!boot_done)
      single_mode <= single_unit_strap;
  end

  // apb slave, zero wait states: answer prepared in the setup cycle
  assign wr_access = psel && penable && pready && pwrite;
  assign rd_setup = psel && !penable;
  always_comb
  begin
    mapped = 1'b1;
    next_rdata = 32'h0000_0000;
    case (paddr)
      dufb_pkg::UNIT_EN_ADDR: next_rdata = {30'h0, unit_en};
      dufb_pkg::CLOCK_MODE_ADDR: next_rdata = {24'h0, clock_mode};
      dufb_pkg::CRYSTAL_CTRL_ADDR: next_rdata = {24'h0, crystal_ctrl};
      dufb_pkg::FAST_TRIM_ADDR: next_rdata = {24'h0, fast_trim};
      dufb_pkg::STATUS_ADDR: next_rdata = {28'h0, slot, unsupported, single_mode, boot_done};
      dufb_pkg::PC_ADDR: next_rdata = {4'h0, pc[1], 4'h0, pc[0]};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= rd_setup;
      pslverr <= rd_setup && !mapped;
      if (rd_setup && !pwrite)
        prdata <= next_rdata;
    end
  end

  // software registers; the unit enable is open to code on either unit
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      unit_en <= dufb_pkg::UNIT_EN_RESET;
      clock_mode <= dufb_pkg::CLOCK_MODE_RESET;
      crystal_ctrl <= dufb_pkg::CRYSTAL_CTRL_RESET;
      fast_trim <= dufb_pkg::FAST_TRIM_RESET;
    end
    else if (wr_access)
    begin
      case (paddr)
        dufb_pkg::UNIT_EN_ADDR: unit_en <= pwdata[1:0];
        dufb_pkg::CLOCK_MODE_ADDR: clock_mode <= pwdata[7:0];
        dufb_pkg::CRYSTAL_CTRL_ADDR: crystal_ctrl <= pwdata[7:0];
        dufb_pkg::FAST_TRIM_ADDR: fast_trim <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // oscillator enables, each from its own bit; clock select and divider from their clock mode fields
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      crystal_osc_en <= 1'b0;
      fast_osc_en <= 1'b1;
      slow_osc_en <= 1'b1;
      sysclk_sel <= dufb_pkg::CLK_SEL_SLOW;
      sysclk_div <= 3'h0;
    end
    else
    begin
      crystal_osc_en <= crystal_ctrl[dufb_pkg::CRYSTAL_EN_BIT];
      fast_osc_en <= clock_mode[dufb_pkg::CLOCK_MODE_FAST_EN_BIT];
      slow_osc_en <= clock_mode[dufb_pkg::CLOCK_MODE_SLOW_EN_BIT];
      sysclk_sel <= clock_mode[dufb_pkg::CLOCK_MODE_SEL_LSB +: 2];
      sysclk_div <= clock_mode[dufb_pkg::CLOCK_MODE_DIV_LSB +: 3];
    end
  end

  // task switch: slot alternates in two-unit mode, sticks to primary otherwise
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      slot <= 1'b0;
    else if (boot_done)
      slot <= single_mode ? 1'b0 : !slot;
  end

  assign owner_en = slot ? (unit_en[dufb_pkg::UNIT_EN_SECONDARY_BIT] && !single_mode)
                         : unit_en[dufb_pkg::UNIT_EN_PRIMARY_BIT];
  assign take_irq = irq_req && !slot && owner_en;
  // no region check: any unit may fetch anywhere past the vectors
  assign next_fetch = take_irq ? dufb_pkg::IRQ_VECTOR : (branch_valid ? branch_target : pc[slot]);

  // program counters; a disabled owner's slot changes nothing
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pc[0] <= dufb_pkg::PRIMARY_RESET_VECTOR;
      pc[1] <= dufb_pkg::SECONDARY_RESET_VECTOR;
      fetch_valid <= 1'b0;
      fetch_addr <= 12'h000;
      fetch_unit <= 1'b0;
      irq_taken <= 1'b0;
    end
    else
    begin
      fetch_valid <= boot_done && owner_en;
      irq_taken <= boot_done && take_irq;
      if (boot_done && owner_en)
      begin
        fetch_addr <= next_fetch;
        fetch_unit <= slot;
        pc[slot] <= next_fetch + 12'h001;
      end
    end
  end

  // unsupported wait or delay in single-unit mode; set wins over clear
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      unsupported <= 1'b0;
    else if (exec_valid && wait_delay_op && single_mode)
      unsupported <= 1'b1;
    else if (wr_access && paddr == dufb_pkg::STATUS_ADDR && pwdata[dufb_pkg::STATUS_UNSUPPORTED_BIT])
      unsupported <= 1'b0;
  end

  // shared datapath: one operation per cycle from whichever unit issues it
  assign unit_live = exec_valid && !wait_delay_op && boot_done
                     && (exec_unit ? (unit_en[1] && !single_mode) : unit_en[0]);
  assign eff_addr = mem_indirect ? dmem[mem_addr] : mem_addr;
  assign eff_ok = eff_addr <= dufb_pkg::DMEM_LAST;
  assign mem_byte = eff_ok ? dmem[eff_addr] : 8'h00;
  assign operand = src_mem ? mem_byte : imm;
  assign acc_sel = exec_unit ? acc_secondary : acc_primary;

  always_comb
  begin
    case (alu_op)
      dufb_pkg::DUFB_OP_PASS: alu_result = operand;
      dufb_pkg::DUFB_OP_ADD: alu_result = acc_sel + operand;
      dufb_pkg::DUFB_OP_SUB: alu_result = acc_sel - operand;
      dufb_pkg::DUFB_OP_AND: alu_result = acc_sel & operand;
      dufb_pkg::DUFB_OP_OR: alu_result = acc_sel | operand;
      dufb_pkg::DUFB_OP_XOR: alu_result = acc_sel ^ operand;
      dufb_pkg::DUFB_OP_BSET: alu_result = mem_byte | (8'h01 << bit_idx);
      dufb_pkg::DUFB_OP_BCLR: alu_result = mem_byte & ~(8'h01 << bit_idx);
      default: alu_result = operand;
    endcase
  end

  // memory has no reset; contents are undefined until software writes
  always_ff @(posedge clock)
  begin
    if (unit_live && dst_mem && eff_ok)
      dmem[eff_addr] <= alu_result;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      acc_primary <= 8'h00;
      acc_secondary <= 8'h00;
      mem_rdata <= 8'h00;
    end
    else if (unit_live)
    begin
      mem_rdata <= mem_byte;
      if (!dst_mem && !exec_unit)
        acc_primary <= alu_result;
      if (!dst_mem && exec_unit)
        acc_secondary <= alu_result;
    end
  end

  // stack location per unit, moved freely by software
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      sp_primary <= 8'h00;
      sp_secondary <= 8'h00;
    end
    else if (unit_live && sp_load)
    begin
      if (exec_unit)
        sp_secondary <= imm;
      else
        sp_primary <= imm;
    end
  end

  property p_single_no_secondary;
    @(posedge clock) disable iff (reset)
    single_mode && fetch_valid |-> !fetch_unit;
  endproperty
  a_single_no_secondary: assert property (p_single_no_secondary) else $error("secondary fetched in single mode");

  property p_unsupported_flag;
    @(posedge clock) disable iff (reset)
    exec_valid && wait_delay_op && single_mode |=> unsupported && $stable(acc_primary);
  endproperty
  a_unsupported_flag: assert property (p_unsupported_flag) else $error("wait or delay not flagged");

  property p_first_fetch;
    @(posedge clock) disable iff (reset)
    $rose(boot_done) && unit_en[0] && !irq_req && !branch_valid |=> fetch_valid && fetch_addr == 12'h000 && !fetch_unit;
  endproperty
  a_first_fetch: assert property (p_first_fetch) else $error("first fetch not at primary vector");

  property p_irq_vector;
    @(posedge clock) disable iff (reset)
    irq_taken |-> fetch_valid && !fetch_unit && fetch_addr == 12'h010;
  endproperty
  a_irq_vector: assert property (p_irq_vector) else $error("interrupt not vectored to primary");

  property p_boot_wait;
    @(posedge clock) disable iff (reset)
    !boot_done |=> !fetch_valid || $past(boot_done);
  endproperty
  a_boot_wait: assert property (p_boot_wait) else $error("fetch before boot wait ends");

  property p_alternate;
    @(posedge clock) disable iff (reset)
    fetch_valid && fetch_unit |=> !(fetch_valid && fetch_unit) ##1 !(fetch_valid && !fetch_unit) || fetch_unit;
  endproperty
  a_alternate: assert property (p_alternate) else $error("slots not alternating");

  property p_pc_advance;
    @(posedge clock) disable iff (reset)
    fetch_valid |-> pc[fetch_unit] == fetch_addr + 12'h001;
  endproperty
  a_pc_advance: assert property (p_pc_advance) else $error("pc not one past the fetch");

  property p_single_every;
    @(posedge clock) disable iff (reset)
    single_mode && boot_done && unit_en[0] |=> fetch_valid && !fetch_unit;
  endproperty
  a_single_every: assert property (p_single_every) else $error("primary missed a cycle");

  property p_disabled_slot;
    @(posedge clock) disable iff (reset)
    boot_done && slot && !owner_en |=> !fetch_valid && $stable(pc[1]);
  endproperty
  a_disabled_slot: assert property (p_disabled_slot) else $error("disabled slot changed state");
endmodule
`default_nettype wire

// ---- verif/dufb_prog_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module dufb_prog_mem (
  input wire logic clock, // system clock
  input wire logic reset, // async, active high
  input wire logic fetch_valid, // fetch request
  input wire logic [11:0] fetch_addr, // word address
  input wire logic fetch_unit, // 0 primary, 1 secondary
  output logic [15:0] instr // fetched word
);
  logic [15:0] words [4096];
  int n_fetch [2];
  initial
  begin
    for (int i = 0; i < 4096; i++)
      words[i] = 16'(i) ^ 16'hA5A5;
  end
  // idle bus inverts the held word each cycle, so a stale word shows again after every second idle cycle
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      instr <= 16'h0000;
      n_fetch[0] <= 0;
      n_fetch[1] <= 0;
    end
    else if (fetch_valid)
    begin
      instr <= words[fetch_addr];
      n_fetch[fetch_unit] <= n_fetch[fetch_unit] + 1;
    end
    else
      instr <= ~instr;
  end
endmodule
`default_nettype wire

// ---- verif/dual_unit_fetch_boot_sequencer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module dual_unit_fetch_boot_sequencer_tb;
  logic clock, reset, psel, penable, pwrite, pready, pslverr, slow_osc_clk, single_unit_strap, irq_req;
  logic branch_valid, exec_valid, exec_unit, src_mem, dst_mem, mem_indirect, sp_load, wait_delay_op;
  logic fetch_valid, fetch_unit, irq_taken, crystal_osc_en, fast_osc_en, slow_osc_en, boot_done, slow_run;
  logic [7:0] paddr, imm, mem_addr, mem_rdata, acc_primary, acc_secondary, sp_primary, sp_secondary, fast_trim;
  logic [31:0] pwdata, prdata;
  logic [11:0] branch_target, fetch_addr;
  logic [2:0] alu_op, bit_idx, sysclk_div;
  logic [1:0] sysclk_sel;
  logic [15:0] instr;
  logic fv [8];
  logic fu [8];
  logic [11:0] fa [8];
  int n_errors, n_compared, n_slow;
  dufb_sequencer dufb_sequencer_i (.clock(clock), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_osc_clk(slow_osc_clk), .single_unit_strap(single_unit_strap), .irq_req(irq_req),
    .branch_valid(branch_valid), .branch_target(branch_target), .exec_valid(exec_valid), .exec_unit(exec_unit),
    .alu_op(alu_op), .src_mem(src_mem), .dst_mem(dst_mem), .imm(imm), .mem_addr(mem_addr),
    .mem_indirect(mem_indirect), .bit_idx(bit_idx), .sp_load(sp_load), .wait_delay_op(wait_delay_op),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .fetch_unit(fetch_unit), .irq_taken(irq_taken),
    .mem_rdata(mem_rdata), .acc_primary(acc_primary), .acc_secondary(acc_secondary), .sp_primary(sp_primary),
    .sp_secondary(sp_secondary), .crystal_osc_en(crystal_osc_en), .fast_osc_en(fast_osc_en),
    .slow_osc_en(slow_osc_en), .sysclk_sel(sysclk_sel), .sysclk_div(sysclk_div), .fast_trim(fast_trim),
    .boot_done(boot_done));
  dufb_prog_mem dufb_prog_mem_i (.clock(clock), .reset(reset), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .fetch_unit(fetch_unit), .instr(instr));
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // slow oscillator runs 8 system clocks per period so the boot wait stays short
  initial
  begin
    slow_osc_clk = 1'b0;
    forever
    begin
      repeat (4) @(posedge clock);
      slow_osc_clk <= slow_run && !slow_osc_clk; // parked low so reset sees no edge
    end
  end
  always @(posedge slow_osc_clk)
    n_slow++;
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    chk(pready, 1'b1, "pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp, what);
  endtask
  task automatic grab(input int n);
    for (int i = 0; i < n; i++)
    begin
      tick(1);
      fv[i] = fetch_valid;
      fa[i] = fetch_addr;
      fu[i] = fetch_unit;
    end
  endtask
  task automatic op(input logic u, input logic [2:0] a, input logic sm, input logic dm, input logic [7:0] im,
                    input logic [7:0] ad, input logic ind, input logic [2:0] b, input logic spl);
    @(posedge clock);
    exec_valid <= 1'b1;
    exec_unit <= u;
    alu_op <= a;
    src_mem <= sm;
    dst_mem <= dm;
    imm <= im;
    mem_addr <= ad;
    mem_indirect <= ind;
    bit_idx <= b;
    sp_load <= spl;
    @(posedge clock);
    exec_valid <= 1'b0;
    sp_load <= 1'b0;
    #1;
  endtask
  task automatic do_reset(input logic single);
    reset <= 1'b1;
    slow_run <= 1'b0;
    single_unit_strap <= single;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    tick(1);
  endtask
  task automatic test_reset();
    logic [31:0] r;
    logic e;
    chk({crystal_osc_en, fast_osc_en, slow_osc_en, sysclk_sel}, 5'b01100, "osc enables");
    chk({boot_done, fetch_valid, fast_trim}, 10'h080, "boot and trim");
    rdc(dufb_pkg::UNIT_EN_ADDR, 32'h1, "unit enable");
    rdc(dufb_pkg::CLOCK_MODE_ADDR, 32'h14, "clock mode");
    rdc(dufb_pkg::CRYSTAL_CTRL_ADDR, 32'h0, "crystal ctrl");
    rdc(dufb_pkg::FAST_TRIM_ADDR, 32'h80, "trim");
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk({e, r}, 33'h100000000, "unmapped read");
    $display("reset test done");
  endtask
  task automatic boot_wait(input logic single);
    int n;
    n_slow = 0;
    slow_run <= 1'b1;
    n = 0;
    while (n_slow < 1023 && n < 20000)
    begin
      @(posedge clock);
      n++;
    end
    tick(6);
    chk(boot_done, 1'b0, "boot too early");
    chk(dufb_prog_mem_i.n_fetch[0] + dufb_prog_mem_i.n_fetch[1], 0, "fetch during boot");
    n = 0;
    while (boot_done !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    chk(n_slow >= 1024 && boot_done === 1'b1, 1'b1, "boot end");
    chk({sysclk_sel, fast_osc_en, slow_osc_en, crystal_osc_en}, 5'b00110, "after boot");
    grab(3);
    chk({fv[0], fu[0], fa[0]}, {2'b10, dufb_pkg::PRIMARY_RESET_VECTOR}, "first fetch");
    chk(fv[1], single, "second slot");
    chk({fv[2], fu[2], fa[2]}, {2'b10, single ? 12'h002 : 12'h001}, "third fetch");
    $display("boot test done");
  endtask
  task automatic test_two_units();
    int k;
    wr(dufb_pkg::UNIT_EN_ADDR, 32'h3);
    grab(8);
    k = 8;
    for (int i = 7; i >= 0; i--)
      if (fv[i] && fu[i])
        k = i;
    chk(k < 8 ? fa[k] : 12'hFFF, dufb_pkg::SECONDARY_RESET_VECTOR, "secondary start");
    for (int i = 2; i < 8; i++)
    begin
      chk({fv[i], fu[i]}, {1'b1, !fu[i-1]}, "slot order");
      chk(fa[i], 12'(fa[i-2] + 12'h001), "pc step");
    end
    $display("two unit test done");
  endtask
  task automatic test_data();
    logic [2:0] ops [4];
    logic [7:0] res [4];
    ops = '{dufb_pkg::DUFB_OP_SUB, dufb_pkg::DUFB_OP_AND, dufb_pkg::DUFB_OP_OR, dufb_pkg::DUFB_OP_XOR};
    res = '{8'h32, 8'h01, 8'h4F, 8'h4E};
    op(0, dufb_pkg::DUFB_OP_PASS, 0, 0, 8'h3C, 8'h00, 0, 0, 0);
    op(0, dufb_pkg::DUFB_OP_ADD, 0, 0, 8'h05, 8'h00, 0, 0, 0);
    chk(acc_primary, 8'h41, "add");
    for (int i = 0; i < 4; i++)
    begin
      op(0, dufb_pkg::DUFB_OP_PASS, 0, 0, 8'h41, 8'h00, 0, 0, 0);
      op(0, ops[i], 0, 0, 8'h0F, 8'h00, 0, 0, 0);
      chk(acc_primary, res[i], "alu op");
    end
    op(0, dufb_pkg::DUFB_OP_PASS, 0, 1, 8'hC3, dufb_pkg::DMEM_LAST, 0, 0, 0);
    op(0, dufb_pkg::DUFB_OP_PASS, 0, 1, dufb_pkg::DMEM_LAST, 8'h10, 0, 0, 0);
    op(1, dufb_pkg::DUFB_OP_PASS, 1, 0, 8'h00, 8'h10, 1, 0, 0);
    chk({acc_secondary, mem_rdata}, 16'hC3C3, "indirect read");
    op(1, dufb_pkg::DUFB_OP_PASS, 0, 1, 8'h0F, 8'h20, 0, 0, 0);
    op(1, dufb_pkg::DUFB_OP_BCLR, 1, 1, 8'h00, 8'h20, 0, 3'd3, 0);
    op(0, dufb_pkg::DUFB_OP_BSET, 1, 1, 8'h00, 8'h20, 0, 3'd6, 0);
    op(0, dufb_pkg::DUFB_OP_PASS, 1, 0, 8'h00, 8'h20, 0, 0, 0);
    chk(acc_primary, 8'h47, "bit ops");
    op(0, dufb_pkg::DUFB_OP_PASS, 0, 1, 8'h99, 8'hD0, 0, 0, 0);
    op(0, dufb_pkg::DUFB_OP_PASS, 1, 0, 8'h00, 8'hD0, 0, 0, 0);
    chk(mem_rdata, 8'h00, "beyond data memory");
    op(0, dufb_pkg::DUFB_OP_PASS, 0, 0, 8'h40, 8'h00, 0, 0, 1);
    op(1, dufb_pkg::DUFB_OP_PASS, 0, 0, 8'h80, 8'h00, 0, 0, 1);
    chk({sp_primary, sp_secondary}, 16'h4080, "stack pointers");
    $display("data test done");
  endtask
  task automatic test_branch_irq();
    int k;
    @(posedge clock);
    branch_valid <= 1'b1;
    branch_target <= 12'hFF0;
    @(posedge clock);
    branch_valid <= 1'b0;
    grab(6);
    chk({fv[1], fu[1], fa[1]}, {1'b1, !fu[0], 12'hFF1}, "branch");
    irq_req <= 1'b1;
    k = 0;
    while (irq_taken !== 1'b1 && k < 8)
    begin
      tick(1);
      k++;
    end
    irq_req <= 1'b0;
    chk({irq_taken, fetch_unit, fetch_addr}, {2'b10, dufb_pkg::IRQ_VECTOR}, "irq vector");
    grab(2);
    chk(fu[1] ? fa[0] : fa[1], 12'h011, "after vector");
    $display("branch and irq test done");
  endtask
  task automatic test_clocks();
    logic [7:0] cm [4];
    cm = '{8'h34, 8'h15, 8'hA6, 8'h14};
    for (int i = 0; i < 4; i++)
    begin
      wr(dufb_pkg::CLOCK_MODE_ADDR, {24'h0, cm[i]});
      tick(2);
      chk({fast_osc_en, slow_osc_en}, {cm[i][4], cm[i][2]}, "osc enables");
      chk({sysclk_div, sysclk_sel}, {cm[i][7:5], cm[i][1:0]}, "clock source");
      rdc(dufb_pkg::CLOCK_MODE_ADDR, {24'h0, cm[i]}, "clock mode");
    end
    wr(dufb_pkg::CRYSTAL_CTRL_ADDR, 32'h80);
    wr(dufb_pkg::FAST_TRIM_ADDR, 32'h5A);
    tick(2);
    chk({crystal_osc_en, fast_osc_en, slow_osc_en, fast_trim}, 11'h75A, "crystal and trim");
    wr(dufb_pkg::CRYSTAL_CTRL_ADDR, 32'h00);
    tick(2);
    chk(crystal_osc_en, 1'b0, "crystal off");
    $display("clock test done");
  endtask
  task automatic test_disable();
    wr(dufb_pkg::UNIT_EN_ADDR, 32'h1);
    tick(1);
    grab(6);
    for (int i = 2; i < 6; i++)
      chk({fv[i], fu[i], fa[i]}, {!fv[i-1], 1'b0, fv[i] ? 12'(fa[i-2] + 12'h001) : fa[i]}, "idle slot");
    $display("disable test done");
  endtask
  task automatic test_single();
    logic [31:0] r;
    logic e;
    wr(dufb_pkg::UNIT_EN_ADDR, 32'h3);
    grab(6);
    for (int i = 1; i < 6; i++)
      chk({fv[i], fu[i], fa[i]}, {2'b10, 12'(fa[i-1] + 12'h001)}, "single mode fetch");
    @(posedge clock);
    wait_delay_op <= 1'b1;
    op(0, dufb_pkg::DUFB_OP_PASS, 0, 0, 8'h77, 8'h00, 0, 0, 0);
    wait_delay_op <= 1'b0;
    chk(acc_primary, 8'h00, "wait op ignored");
    apb(1'b0, dufb_pkg::STATUS_ADDR, 32'h0, r, e);
    chk(r[3:0], 4'b0111, "status flags");
    $display("single mode test done");
  endtask
  initial
  begin
    reset = 1'b1;
    {psel, penable, pwrite, single_unit_strap, irq_req, branch_valid, exec_valid, exec_unit} = 8'h00;
    {src_mem, dst_mem, mem_indirect, sp_load, wait_delay_op, slow_run} = 6'h00;
    {paddr, imm, mem_addr, pwdata, branch_target, alu_op, bit_idx} = 74'h0;
    n_errors = 0;
    n_compared = 0;
    n_slow = 0;
    do_reset(1'b0);
    test_reset();
    boot_wait(1'b0);
    test_two_units();
    test_data();
    test_branch_irq();
    test_clocks();
    test_disable();
    do_reset(1'b1);
    boot_wait(1'b1);
    test_single();
    complete_run();
  end
  // about twice the two boot waits plus the register traffic
  initial
  begin
    repeat (40000) @(posedge clock);
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
`default_nettype wire
